// ==== rtl/strap_ratio_pkg.sv ====
/*
  constants for the power-up clock ratio strap decoder: strap codes, decoded
  ratios, frequency limits and register offsets.
  assumes a single 25 MHz reference clock domain.
*/
`default_nettype none
package strap_ratio_pkg;
  // platform ratio strap codes
  localparam logic [3:0] PLAT_X16 = 4'h0;
  localparam logic [3:0] PLAT_X3 = 4'h3;
  localparam logic [3:0] PLAT_X4 = 4'h4;
  localparam logic [3:0] PLAT_X5 = 4'h5;
  localparam logic [3:0] PLAT_X6 = 4'h6;
  localparam logic [3:0] PLAT_X8 = 4'h8;
  localparam logic [3:0] PLAT_X9 = 4'h9;
  localparam logic [3:0] PLAT_X10 = 4'ha;
  localparam logic [3:0] PLAT_X12 = 4'hc;
  // core ratio strap codes; ratio given in half steps (core = plat * half / 2)
  localparam logic [2:0] CORE_4_1 = 3'h0;
  localparam logic [2:0] CORE_3_2 = 3'h3;
  localparam logic [2:0] CORE_2_1 = 3'h4;
  localparam logic [2:0] CORE_5_2 = 3'h5;
  localparam logic [2:0] CORE_3_1 = 3'h6;
  localparam logic [2:0] CORE_7_2 = 3'h7;
  // crypto engine divider
  localparam logic [1:0] CRYPTO_DIV_2 = 2'h2;
  localparam logic [1:0] CRYPTO_DIV_3 = 2'h3;
  localparam logic CRYPTO_STRAP_DEFAULT = 1'b1;
  // frequency limits in MHz, then the fifo clock percentage of platform and its scale
  localparam logic [15:0] PLAT_MIN_MHZ = 16'h014d;
  localparam logic [15:0] CRYPTO_2_1_MAX_MHZ = 16'h0190;
  localparam logic [15:0] CORE_MIN_MHZ = 16'h029b;
  localparam logic [15:0] CORE_MAX_MHZ = 16'h042b;
  localparam logic [15:0] MEM_MIN_MHZ = 16'h00a6;
  localparam logic [15:0] MEM_MAX_MHZ = 16'h010a;
  localparam logic [15:0] PCI_REF_MIN_MHZ = 16'h0021;
  localparam logic [15:0] PCI_REF_MAX_MHZ = 16'h0042;
  localparam logic [15:0] FIFO_PCT = 16'h0018;
  localparam logic [15:0] PCT_SCALE = 16'h0064;
  // register offsets
  localparam logic [3:0] REG_STRAPS = 4'h0;
  localparam logic [3:0] REG_RATIOS = 4'h1;
  localparam logic [3:0] REG_REF_MHZ = 4'h2;
  localparam logic [3:0] REG_PLAT_MHZ = 4'h3;
  localparam logic [3:0] REG_CORE_MHZ = 4'h4;
  localparam logic [3:0] REG_MEM_MHZ = 4'h5;
  localparam logic [3:0] REG_FIFO_MHZ = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;
  // status bit positions
  localparam int ST_PLAT_RSVD = 0;
  localparam int ST_CORE_RSVD = 1;
  localparam int ST_CRYPTO_BAD = 2;
  localparam int ST_CORE_RANGE = 3;
  localparam int ST_PLAT_RANGE = 4;
  localparam int ST_MEM_RANGE = 5;
  localparam int ST_PCI_NEEDED = 6;
  localparam int ST_LATCHED = 7;
  // power-on reference frequency default
  localparam logic [15:0] REF_MHZ_RESET = 16'h0042;
  // enabled edges after reset release before sync stage 2 holds a pin sample
  localparam logic [1:0] SYNC_FILL = 2'h2;
endpackage : strap_ratio_pkg
`default_nettype wire

// ==== rtl/strap_clock_ratio_config.sv ====
/*
  strap_clock_ratio_config: catches the clock ratio straps once after power-on
  reset, decodes them into platform, core and crypto engine ratios, and
  reports derived frequencies and limit checks over a plain register port.
  assumes straps come from board pins (synchronised here) and that software
  writes the reference frequency in MHz so the frequency checks mean something.
*/
// What this block does
// - decode four platform straps into multipliers 16,3,4,5,6,8,9,10,12; rest reserved
// - decode three core straps into 4:1,3:2,2:1,5:2,3:1,7:2; 001,010 reserved
// - crypto strap 0 selects 2:1, 1 selects 3:1 platform to engine
// - crypto ratio defaults to 3:1, valid at any platform frequency
// - memory bus clock is half platform, within 166 to 266 MHz
// - platform clock and core complex bus clock are one signal
`default_nettype none
module strap_clock_ratio_config #(
  parameter logic [15:0] CORE_GRADE_MAX_MHZ = strap_ratio_pkg::CORE_MAX_MHZ
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] platform_ratio_straps,
  input wire logic core_ratio_strap_msb,
  input wire logic core_ratio_strap_mid,
  input wire logic core_ratio_strap_lsb,
  input wire logic crypto_ratio_strap,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [4:0] plat_mult,
  output logic [3:0] core_half_ratio,
  output logic [1:0] crypto_div,
  output logic straps_latched,
  output logic cfg_error
);
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b01,
    ST_HOLD = 2'b10
  } latch_state_t;

  latch_state_t state_r;
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] straps_r;
  logic [1:0] fill_r;
  logic [15:0] ref_mhz_r;
  logic [15:0] rdata_r;
  logic [4:0] mult_w;
  logic [3:0] half_w;
  logic plat_rsvd_w;
  logic core_rsvd_w;
  logic [15:0] plat_mhz_w;
  logic [15:0] core_mhz_w;
  logic [15:0] mem_mhz_w;
  logic [15:0] fifo_mhz_w;
  logic [7:0] status_w;
  logic [31:0] plat_prod_w;
  logic [31:0] core_prod_w;
  logic [31:0] fifo_prod_w;

  // pin straps pass two flops before anything looks at them
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else if (clk_en) begin
      sync1_r <= {platform_ratio_straps, core_ratio_strap_msb, core_ratio_strap_mid,
                  core_ratio_strap_lsb, crypto_ratio_strap};
      sync2_r <= sync1_r;
    end
  end

  // catch straps once after reset release, then hold them until next reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_SAMPLE;
      straps_r <= {7'h00, strap_ratio_pkg::CRYPTO_STRAP_DEFAULT};
    end else if (clk_en) begin
      unique case (state_r)
        ST_SAMPLE: begin
          if (fill_r == strap_ratio_pkg::SYNC_FILL) begin
            straps_r <= sync2_r;
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: state_r <= ST_HOLD;
        default: state_r <= ST_SAMPLE;
      endcase
    end
  end

  // sync flops come out of reset as zeros: count two enabled edges so the
  // capture sees a real pin sample, not the cleared pipeline
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fill_r <= 2'h0;
    end else if (clk_en && fill_r != strap_ratio_pkg::SYNC_FILL) begin
      fill_r <= fill_r + 2'h1;
    end
  end

  // platform multiplier decode
  always_comb begin
    plat_rsvd_w = 1'b0;
    unique case (straps_r[7:4])
      strap_ratio_pkg::PLAT_X16: mult_w = 5'd16;
      strap_ratio_pkg::PLAT_X3: mult_w = 5'd3;
      strap_ratio_pkg::PLAT_X4: mult_w = 5'd4;
      strap_ratio_pkg::PLAT_X5: mult_w = 5'd5;
      strap_ratio_pkg::PLAT_X6: mult_w = 5'd6;
      strap_ratio_pkg::PLAT_X8: mult_w = 5'd8;
      strap_ratio_pkg::PLAT_X9: mult_w = 5'd9;
      strap_ratio_pkg::PLAT_X10: mult_w = 5'd10;
      strap_ratio_pkg::PLAT_X12: mult_w = 5'd12;
      default: begin
        mult_w = 5'd0; // no default multiplier exists
        plat_rsvd_w = 1'b1;
      end
    endcase
  end

  // core ratio decode in half steps
  always_comb begin
    core_rsvd_w = 1'b0;
    unique case (straps_r[3:1])
      strap_ratio_pkg::CORE_4_1: half_w = 4'd8;
      strap_ratio_pkg::CORE_3_2: half_w = 4'd3;
      strap_ratio_pkg::CORE_2_1: half_w = 4'd4;
      strap_ratio_pkg::CORE_5_2: half_w = 4'd5;
      strap_ratio_pkg::CORE_3_1: half_w = 4'd6;
      strap_ratio_pkg::CORE_7_2: half_w = 4'd7;
      default: begin
        half_w = 4'd0;
        core_rsvd_w = 1'b1;
      end
    endcase
  end

  // derived frequencies; platform is also the core complex bus clock
  assign plat_prod_w = 32'(ref_mhz_r) * 32'(mult_w);
  assign plat_mhz_w = plat_prod_w[15:0];
  assign core_prod_w = (32'(plat_mhz_w) * 32'(half_w)) >> 1;
  assign core_mhz_w = core_prod_w[15:0];
  assign mem_mhz_w = {1'b0, plat_mhz_w[15:1]};
  assign fifo_prod_w = (32'(plat_mhz_w) * 32'(strap_ratio_pkg::FIFO_PCT)) /
                       32'(strap_ratio_pkg::PCT_SCALE);
  assign fifo_mhz_w = fifo_prod_w[15:0];

  // limit checks collected into status
  assign status_w[strap_ratio_pkg::ST_PLAT_RSVD] = plat_rsvd_w;
  assign status_w[strap_ratio_pkg::ST_CORE_RSVD] = core_rsvd_w;
  assign status_w[strap_ratio_pkg::ST_CRYPTO_BAD] = !straps_r[0] &&
    (plat_mhz_w > strap_ratio_pkg::CRYPTO_2_1_MAX_MHZ);
  assign status_w[strap_ratio_pkg::ST_CORE_RANGE] = (core_mhz_w < strap_ratio_pkg::CORE_MIN_MHZ)
    || (core_mhz_w > CORE_GRADE_MAX_MHZ);
  assign status_w[strap_ratio_pkg::ST_PLAT_RANGE] =
    plat_mhz_w < strap_ratio_pkg::PLAT_MIN_MHZ;
  assign status_w[strap_ratio_pkg::ST_MEM_RANGE] = (mem_mhz_w < strap_ratio_pkg::MEM_MIN_MHZ)
    || (mem_mhz_w > strap_ratio_pkg::MEM_MAX_MHZ);
  assign status_w[strap_ratio_pkg::ST_PCI_NEEDED] =
    (ref_mhz_r < strap_ratio_pkg::PCI_REF_MIN_MHZ) ||
    (ref_mhz_r > strap_ratio_pkg::PCI_REF_MAX_MHZ);
  assign status_w[strap_ratio_pkg::ST_LATCHED] = (state_r == ST_HOLD);

  // register writes: only the reference frequency is writable
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ref_mhz_r <= strap_ratio_pkg::REF_MHZ_RESET;
    end else if (clk_en && reg_wr && reg_addr == strap_ratio_pkg::REG_REF_MHZ) begin
      ref_mhz_r <= reg_wdata;
    end
  end

  // read mux, data valid in the cycle after the strobe
  logic [15:0] rmux_w;
  always_comb begin
    unique case (reg_addr)
      strap_ratio_pkg::REG_STRAPS: rmux_w = {8'h00, straps_r};
      strap_ratio_pkg::REG_RATIOS: rmux_w = {5'h00, crypto_div, half_w, mult_w};
      strap_ratio_pkg::REG_REF_MHZ: rmux_w = ref_mhz_r;
      strap_ratio_pkg::REG_PLAT_MHZ: rmux_w = plat_mhz_w;
      strap_ratio_pkg::REG_CORE_MHZ: rmux_w = core_mhz_w;
      strap_ratio_pkg::REG_MEM_MHZ: rmux_w = mem_mhz_w;
      strap_ratio_pkg::REG_FIFO_MHZ: rmux_w = fifo_mhz_w;
      strap_ratio_pkg::REG_STATUS: rmux_w = {8'h00, status_w};
      default: rmux_w = 16'h0000; // unmapped reads as zero
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else if (clk_en) begin
      rdata_r <= reg_rd ? rmux_w : 16'h0000;
    end
  end

  // registered decode outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      plat_mult <= 5'h00;
      core_half_ratio <= 4'h0;
      crypto_div <= strap_ratio_pkg::CRYPTO_DIV_3;
      straps_latched <= 1'b0;
      cfg_error <= 1'b0;
    end else if (clk_en && state_r == ST_HOLD) begin
      plat_mult <= mult_w;
      core_half_ratio <= half_w;
      crypto_div <= straps_r[0] ? strap_ratio_pkg::CRYPTO_DIV_3
                                : strap_ratio_pkg::CRYPTO_DIV_2;
      straps_latched <= 1'b1;
      cfg_error <= |status_w[6:0];
    end
  end

  assign reg_rdata = rdata_r;
endmodule : strap_clock_ratio_config
`default_nettype wire

// ==== test/strap_ratio_sva.sv ====
/* port checker for the strap ratio decoder.
   assumes a bind onto the top module, one clock domain. */
`default_nettype none
module strap_ratio_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] platform_ratio_straps,
  input wire logic core_ratio_strap_msb,
  input wire logic core_ratio_strap_mid,
  input wire logic core_ratio_strap_lsb,
  input wire logic crypto_ratio_strap,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [4:0] plat_mult,
  input wire logic [3:0] core_half_ratio,
  input wire logic [1:0] crypto_div,
  input wire logic straps_latched
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // core code as seen on the three pins, msb first
  wire logic [2:0] core_code = {core_ratio_strap_msb, core_ratio_strap_mid, core_ratio_strap_lsb};
  wire logic plat_ok = platform_ratio_straps inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc};
  // expected decodes; legal codes other than 0 equal their value
  wire logic [4:0] plat_exp = (platform_ratio_straps == 4'h0) ? 5'h10 :
    (plat_ok ? {1'b0, platform_ratio_straps} : 5'h00);
  wire logic [3:0] core_exp = (core_code == 3'h0) ? 4'h8 :
    ((core_code < 3'h3) ? 4'h0 : {1'b0, core_code});
  plat_dec_a: assert property (
    $rose(straps_latched) |-> plat_mult == plat_exp) else $error("platform decode wrong");
  core_dec_a: assert property (
    $rose(straps_latched) |-> core_half_ratio == core_exp) else $error("core decode wrong");
  crypto_sel_a: assert property (
    $rose(straps_latched) |-> crypto_div == (crypto_ratio_strap ? 2'h3 : 2'h2))
    else $error("crypto divider wrong");
  crypto_def_a: assert property (
    $rose(rst_n) |-> crypto_div == 2'h3) else $error("crypto default not 3");
  latch_time_a: assert property (
    $rose(rst_n) |-> ##[1:4] straps_latched) else $error("straps not latched in time");
  latch_hold_a: assert property (
    straps_latched && $past(straps_latched) |-> $stable(plat_mult) && $stable(core_half_ratio)
    && $stable(crypto_div)) else $error("ratios changed after latch");
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data not idle");
  // main scenarios
  cover property ($rose(straps_latched) && plat_mult == 5'h00);
  cover property ($rose(straps_latched) && crypto_div == 2'h2);
  cover property (reg_rd ##1 reg_rdata != 16'h0000);
endmodule : strap_ratio_sva
`default_nettype wire

// ==== test/strap_board_model.sv ====
/* board strap resistors: turns the chosen codes into strap pin levels.
   assumes the bench picks a code and holds it over a power-on reset. */
`default_nettype none
module strap_board_model (
  input wire logic [3:0] sel_plat,
  input wire logic [2:0] sel_core,
  input wire logic sel_crypto,
  output logic [3:0] platform_ratio_straps,
  output logic core_ratio_strap_msb,
  output logic core_ratio_strap_mid,
  output logic core_ratio_strap_lsb,
  output logic crypto_ratio_strap
);
  timeunit 1ns;
  timeprecision 1ps;
  // every strap is pulled to a definite level, never left floating
  assign platform_ratio_straps = sel_plat;
  assign {core_ratio_strap_msb, core_ratio_strap_mid, core_ratio_strap_lsb} = sel_core;
  assign crypto_ratio_strap = sel_crypto;
endmodule : strap_board_model
`default_nettype wire

// ==== test/strap_clock_ratio_config_tb_top.sv ====
/* self-checking bench for the strap ratio decoder.
   assumes the board model drives the straps and one 25 MHz clock. */
`default_nettype none
module strap_clock_ratio_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] sel_plat = 4'h0;
  logic [2:0] sel_core = 3'h0;
  logic sel_crypto = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire logic [3:0] plat_pins;
  wire logic c_msb, c_mid, c_lsb, s_pin;
  logic [15:0] reg_rdata;
  logic [4:0] plat_mult;
  logic [3:0] core_half_ratio;
  logic [1:0] crypto_div;
  logic straps_latched;
  logic cfg_error;
  int n_errors = 0;
  int total_checks = 0;
  always #20 ref_clk = ~ref_clk;
  strap_board_model board (.sel_plat(sel_plat), .sel_core(sel_core), .sel_crypto(sel_crypto),
    .platform_ratio_straps(plat_pins), .core_ratio_strap_msb(c_msb),
    .core_ratio_strap_mid(c_mid), .core_ratio_strap_lsb(c_lsb), .crypto_ratio_strap(s_pin));
  strap_clock_ratio_config uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
    .platform_ratio_straps(plat_pins), .core_ratio_strap_msb(c_msb),
    .core_ratio_strap_mid(c_mid), .core_ratio_strap_lsb(c_lsb), .crypto_ratio_strap(s_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .plat_mult(plat_mult), .core_half_ratio(core_half_ratio),
    .crypto_div(crypto_div), .straps_latched(straps_latched), .cfg_error(cfg_error));
  // expected ratio register: {divider, core half ratio, multiplier}
  function automatic logic [15:0] ratio(input logic [3:0] p, input logic [2:0] c, input logic s);
    logic [4:0] m;
    logic [3:0] h;
    m = (p == 4'h0) ? 5'h10 : ((p inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc})
      ? {1'b0, p} : 5'h00);
    h = (c == 3'h0) ? 4'h8 : ((c < 3'h3) ? 4'h0 : {1'b0, c});
    return {5'h00, (s ? 2'h3 : 2'h2), h, m};
  endfunction : ratio
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk(reg_rdata, e);
  endtask : rd
  // power-on reset with the given straps, then wait for the latch
  task automatic cfg(input logic [3:0] p, input logic [2:0] c, input logic s);
    sel_plat <= p;
    sel_core <= c;
    sel_crypto <= s;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 8; k++) if (straps_latched !== 1'b1) @(posedge ref_clk);
    chk({15'h0000, straps_latched}, 16'h0001);
  endtask : cfg
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  initial begin
    @(posedge ref_clk);
    // every platform code, every core code, both crypto settings
    for (int i = 0; i < 16; i++) begin
      cfg(i[3:0], i[2:0], i[0]);
      rd(strap_ratio_pkg::REG_RATIOS, ratio(i[3:0], i[2:0], i[0]));
    end
    // a legal set: 66 MHz ref, 6:1 platform, 2:1 core, 3:1 crypto
    cfg(4'h6, 3'h4, 1'b1);
    rd(strap_ratio_pkg::REG_STATUS, 16'h0080);
    chk({15'h0000, cfg_error}, 16'h0000);
    cfg(4'hc, 3'h7, 1'b0);
    rd(strap_ratio_pkg::REG_REF_MHZ, 16'h0042);
    wr(strap_ratio_pkg::REG_REF_MHZ, 16'h0021);
    rd(strap_ratio_pkg::REG_REF_MHZ, 16'h0021);
    rd(strap_ratio_pkg::REG_PLAT_MHZ, 16'h018c);
    rd(strap_ratio_pkg::REG_MEM_MHZ, 16'h00c6);
    rd(strap_ratio_pkg::REG_CORE_MHZ, 16'h056a);
    wr(strap_ratio_pkg::REG_PLAT_MHZ, 16'h0000);
    rd(strap_ratio_pkg::REG_PLAT_MHZ, 16'h018c);
    rd(4'h8, 16'h0000);
    rd(strap_ratio_pkg::REG_STRAPS, 16'h00ce);
    rd(strap_ratio_pkg::REG_FIFO_MHZ, 16'h005f);
    rd(strap_ratio_pkg::REG_STATUS, 16'h0088);
    chk({15'h0000, cfg_error}, 16'h0001);
    // 2:1 crypto with platform above 400 MHz
    wr(strap_ratio_pkg::REG_REF_MHZ, 16'h0022);
    rd(strap_ratio_pkg::REG_STATUS, 16'h008c);
    // reference below 33 MHz needs the separate PCI clock
    wr(strap_ratio_pkg::REG_REF_MHZ, 16'h001e);
    rd(strap_ratio_pkg::REG_STATUS, 16'h00c8);
    // platform under 333 MHz and memory bus out of range
    wr(strap_ratio_pkg::REG_REF_MHZ, 16'h000a);
    rd(strap_ratio_pkg::REG_STATUS, 16'h00f8);
    // pins move after the latch: decode must not follow
    sel_plat <= 4'h3;
    sel_core <= 3'h4;
    sel_crypto <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(strap_ratio_pkg::REG_RATIOS, ratio(4'hc, 3'h7, 1'b0));
    test_done();
  end
  // cut a hang short
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
endmodule : strap_clock_ratio_config_tb_top
bind strap_clock_ratio_config strap_ratio_sva chk_i (.ref_clk, .rst_n, .platform_ratio_straps,
  .core_ratio_strap_msb, .core_ratio_strap_mid, .core_ratio_strap_lsb, .crypto_ratio_strap,
  .reg_rd, .reg_rdata, .plat_mult, .core_half_ratio, .crypto_div, .straps_latched);
`default_nettype wire
